//--- verilog/msfp_pkg.sv
// shared constants and carrier types for the float and pass-through slave
// Behaviour
// - Outside the float region each 16-bit register is one word, so a float takes two registers.
// - In the float region a register count of one answers four bytes, one whole float.
// - The float region start and base only act while float mode enable is set.
// - The float region start is the zero-based holding register offset of the first float address.
// - Each address step in the float region moves the word index on by two.
// - The float region base is the word index of the first float address.
// - Normally reads come from the outbound data area and writes go to the inbound data area.
// - In pass-through mode writes never reach the inbound area and reads come from the outbound area.
// - A pass-through write builds a block that stays pending until the host confirms it.
// - A pass-through write of 1 to PT_DEPTH words while a block is pending is refused with code 6 and its data is thrown away.
package msfp_pkg;
    localparam int ADDR_W = 16;
    localparam int CNT_W  = 8;
    localparam int WORD_W = 16;
    localparam int TOT_W  = CNT_W + 1;
    localparam int PT_DEPTH_DEF = 256;

    localparam logic [7:0] EXC_VALUE = 8'h03;
    localparam logic [7:0] EXC_BUSY  = 8'h06;

    typedef struct packed {
        logic                  float_mode_enable;
        logic [ADDR_W-1:0]     float_region_start;
        logic [ADDR_W-1:0]     float_region_base;
        logic                  pass_thru_en;
    } msfp_cfg_t;

    typedef struct packed {
        logic                  valid;
        logic                  write;
        logic [ADDR_W-1:0]     addr;
        logic [CNT_W-1:0]      count;
    } msfp_req_t;

    typedef struct packed {
        logic                  valid;
        logic [WORD_W-1:0]     data;
    } msfp_wdat_t;

    typedef struct packed {
        logic                  valid;
        logic                  last;
        logic                  done;
        logic                  exc;
        logic [7:0]            code;
        logic [WORD_W-1:0]     data;
    } msfp_rsp_t;

    typedef struct packed {
        logic                  en;
        logic [ADDR_W-1:0]     addr;
        logic [WORD_W-1:0]     data;
    } msfp_wr_t;

    typedef struct packed {
        logic                  pending;
        logic [ADDR_W-1:0]     word_addr;
        logic [TOT_W-1:0]      word_count;
    } msfp_pt_t;

    localparam msfp_rsp_t RSP_RST  = '0;
    localparam msfp_wr_t  WR_RST   = '0;
    localparam msfp_pt_t  PT_RST   = '0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
    localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
endpackage

//--- verilog/msfp_ptbuf.sv
// flip-flop word store for the pending pass-through block
`timescale 1ns/10ps
module msfp_ptbuf #(
    parameter int WORD_W = 16,
    parameter int DEPTH  = 256,
    parameter int IDX_W  = $clog2(DEPTH)
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rstn,
    // fill side
    input  wire logic              wr_en,
    input  wire logic [IDX_W-1:0]  wr_idx,
    input  wire logic [WORD_W-1:0] wr_data,
    // host read side
    input  wire logic [IDX_W-1:0]  rd_idx,
    output logic      [WORD_W-1:0] rd_data
);
    logic [WORD_W-1:0] mem      [DEPTH];
    logic [WORD_W-1:0] next_mem [DEPTH];
    logic [WORD_W-1:0] next_rd_data;

    genvar i;
    generate
        for (i = 0; i < DEPTH; i++)
        begin : g_word
            always_comb
            begin
                next_mem[i] = mem[i];
                if (wr_en && wr_idx == IDX_W'(i))
                    next_mem[i] = wr_data;
            end
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                    mem[i] <= '0;
                else
                    mem[i] <= next_mem[i];
            end
        end
    endgenerate

    always_comb
    begin
        next_rd_data = mem[rd_idx];
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rd_data <= '0;
        else
            rd_data <= next_rd_data;
    end
endmodule

//--- verilog/msfp_slave.sv
// slave address translation with float region and pass-through blocks
`timescale 1ns/10ps
module msfp_slave
    import msfp_pkg::*;
#(
    parameter int PT_DEPTH = msfp_pkg::PT_DEPTH_DEF,
    parameter int IDX_W    = $clog2(PT_DEPTH)
) (
    // clock and reset
    input  wire logic                         CORE_CLK,
    input  wire logic                         RSTN,
    // configuration
    input  wire msfp_pkg::msfp_cfg_t          CFG,
    // decoded master request and write words
    input  wire msfp_pkg::msfp_req_t          REQ,
    input  wire msfp_pkg::msfp_wdat_t         WDAT,
    // outbound data area read port
    output logic [msfp_pkg::ADDR_W-1:0]       OUT_RD_ADDR,
    input  wire logic [msfp_pkg::WORD_W-1:0]  OUT_RD_DATA,
    // inbound data area write port
    output msfp_pkg::msfp_wr_t                IN_WR,
    // answer to the master
    output msfp_pkg::msfp_rsp_t               RSP,
    // pass-through block to the host
    output msfp_pkg::msfp_pt_t                PT,
    input  wire logic [IDX_W-1:0]             PT_RD_IDX,
    output logic [msfp_pkg::WORD_W-1:0]       PT_RD_DATA,
    input  wire logic                         PT_ACK
);
    import msfp_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_DROP} msfp_st_t;

    msfp_st_t          state, next_state;
    logic [ADDR_W-1:0] next_out_rd_addr;
    logic [TOT_W-1:0]  left, next_left;
    logic [IDX_W-1:0]  idx, next_idx;
    logic              pass_lat, next_pass_lat;
    msfp_wr_t          next_in_wr;
    msfp_rsp_t         next_rsp;
    msfp_pt_t          next_pt;
    logic              buf_wr;
    logic              in_float;
    logic [ADDR_W-1:0] req_word;
    logic [TOT_W-1:0]  req_total;
    logic              take;

    // float region membership, gated by the enable
    function automatic logic is_float(msfp_cfg_t c, logic [ADDR_W-1:0] a);
        return c.float_mode_enable && (a >= c.float_region_start);
    endfunction

    // register offset to module word index
    function automatic logic [ADDR_W-1:0] word_of(msfp_cfg_t c,
                                                  logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] d;
        d = a - c.float_region_start;
        if (is_float(c, a))
            return c.float_region_base + {d[ADDR_W-2:0], 1'b0};
        return a;
    endfunction

    always_comb
    begin
        take      = (state == ST_IDLE) && REQ.valid;
        in_float  = is_float(CFG, REQ.addr);
        req_word  = word_of(CFG, REQ.addr);
        // two words per register in the float region
        req_total = in_float ? {REQ.count, 1'b0} : {1'b0, REQ.count};
    end

    always_comb
    begin
        next_state       = state;
        next_out_rd_addr = OUT_RD_ADDR;
        next_left        = left;
        next_idx         = idx;
        next_pass_lat    = pass_lat;
        next_in_wr       = WR_RST;
        next_rsp         = RSP_RST;
        next_pt          = PT;
        buf_wr           = 1'b0;
        if (PT_ACK)
            next_pt.pending = 1'b0;
        case (state)
            ST_IDLE:
            begin
                if (take)
                begin
                    next_left     = req_total;
                    next_pass_lat = CFG.pass_thru_en;
                    next_idx      = '0;
                    if (REQ.count == '0
                        || (REQ.write && CFG.pass_thru_en
                            && int'(req_total) > PT_DEPTH))
                    begin
                        next_rsp.exc  = 1'b1;
                        next_rsp.code = EXC_VALUE;
                        next_state    = (REQ.count == '0) ? ST_IDLE : ST_DROP;
                    end
                    else if (REQ.write && CFG.pass_thru_en && PT.pending)
                    begin
                        next_rsp.exc  = 1'b1;
                        next_rsp.code = EXC_BUSY;
                        next_state    = ST_DROP;
                    end
                    else
                    begin
                        next_out_rd_addr = req_word;
                        next_state = REQ.write ? ST_WRITE : ST_READ;
                        // a normal write must not move a pending block
                        if (REQ.write && CFG.pass_thru_en)
                            next_pt.word_addr = req_word;
                    end
                end
            end
            ST_READ:
            begin
                // reads always from the outbound area, low word first
                next_rsp.valid   = 1'b1;
                next_rsp.data    = OUT_RD_DATA;
                next_rsp.last    = (left == TOT_W'(1));
                next_out_rd_addr = OUT_RD_ADDR + ADDR_W'(1);
                next_left        = left - TOT_W'(1);
                if (left == TOT_W'(1))
                    next_state = ST_IDLE;
            end
            ST_WRITE:
            begin
                if (WDAT.valid)
                begin
                    if (pass_lat)
                        buf_wr = 1'b1;
                    else
                    begin
                        next_in_wr.en   = 1'b1;
                        next_in_wr.addr = OUT_RD_ADDR;
                        next_in_wr.data = WDAT.data;
                    end
                    next_out_rd_addr = OUT_RD_ADDR + ADDR_W'(1);
                    next_idx         = idx + IDX_W'(1);
                    next_left        = left - TOT_W'(1);
                    if (left == TOT_W'(1))
                    begin
                        next_state    = ST_IDLE;
                        next_rsp.done = 1'b1;
                        if (pass_lat)
                        begin
                            // set wins over a same-cycle confirmation
                            next_pt.pending    = 1'b1;
                            next_pt.word_count = TOT_W'(idx) + TOT_W'(1);
                        end
                    end
                end
            end
            ST_DROP:
            begin
                // refused data is swallowed, never stored
                if (WDAT.valid)
                begin
                    next_left = left - TOT_W'(1);
                    if (left == TOT_W'(1))
                        next_state = ST_IDLE;
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            state       <= ST_IDLE;
            OUT_RD_ADDR <= ADDR_RST;
            left        <= '0;
            idx         <= '0;
            pass_lat    <= 1'b0;
            IN_WR       <= WR_RST;
            RSP         <= RSP_RST;
            PT          <= PT_RST;
        end
        else
        begin
            state       <= next_state;
            OUT_RD_ADDR <= next_out_rd_addr;
            left        <= next_left;
            idx         <= next_idx;
            pass_lat    <= next_pass_lat;
            IN_WR       <= next_in_wr;
            RSP         <= next_rsp;
            PT          <= next_pt;
        end
    end

    msfp_ptbuf #(
        .WORD_W (WORD_W),
        .DEPTH  (PT_DEPTH),
        .IDX_W  (IDX_W)
    ) u_ptbuf (
        .clk     (CORE_CLK),
        .rstn    (RSTN),
        .wr_en   (buf_wr),
        .wr_idx  (idx),
        .wr_data (WDAT.data),
        .rd_idx  (PT_RD_IDX),
        .rd_data (PT_RD_DATA)
    );

    // checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);

    a_std_word_count: assert property (take && !REQ.write && !in_float
        && REQ.count != '0 |=> left == TOT_W'($past(REQ.count)))
        else $error("standard read word count wrong");
    a_float_four_bytes: assert property (take && !REQ.write && in_float
        && REQ.count == 8'h01 |=> left == TOT_W'(2) ##1 RSP.valid
        && !RSP.last ##1 RSP.valid && RSP.last)
        else $error("float register did not give two words");
    a_flag_gates: assert property (take && !REQ.write
        && !CFG.float_mode_enable && REQ.count != '0
        |=> OUT_RD_ADDR == $past(REQ.addr))
        else $error("float settings acted while disabled");
    a_start_edge: assert property (take && !REQ.write
        && CFG.float_mode_enable && REQ.count != '0
        && REQ.addr == CFG.float_region_start - ADDR_W'(1)
        && CFG.float_region_start != ADDR_RST
        |=> OUT_RD_ADDR == $past(REQ.addr))
        else $error("address below float start translated");
    a_float_step: assert property (take && !REQ.write
        && CFG.float_mode_enable && REQ.count != '0
        && REQ.addr == CFG.float_region_start + ADDR_W'(1)
        && REQ.addr > CFG.float_region_start
        |=> OUT_RD_ADDR == $past(CFG.float_region_base) + ADDR_W'(2))
        else $error("float address step not two words");
    a_float_base: assert property (take && !REQ.write
        && CFG.float_mode_enable && REQ.count != '0
        && REQ.addr == CFG.float_region_start
        |=> OUT_RD_ADDR == $past(CFG.float_region_base))
        else $error("first float address not at base");
    a_normal_write: assert property (state == ST_WRITE && !pass_lat
        && WDAT.valid |=> IN_WR.en && IN_WR.data == $past(WDAT.data))
        else $error("normal write not stored inbound");
    a_pt_no_store: assert property (pass_lat && state != ST_IDLE
        |=> !IN_WR.en)
        else $error("pass-through write reached inbound area");
    a_pt_pending: assert property (state == ST_WRITE && pass_lat
        && WDAT.valid && left == TOT_W'(1)
        |=> PT.pending && RSP.done ##1 (PT.pending || $past(PT_ACK)))
        else $error("pass-through block not held pending");
    a_busy_reject: assert property (take && REQ.write
        && CFG.pass_thru_en && PT.pending && REQ.count != '0
        && int'(req_total) <= PT_DEPTH
        |=> RSP.exc && RSP.code == EXC_BUSY && state == ST_DROP
        ##1 !IN_WR.en && !RSP.done)
        else $error("busy write not refused with code 6");
    a_block_held: assert property (PT.pending && !PT_ACK
        |=> PT.word_addr == $past(PT.word_addr))
        else $error("pending block address changed");
    a_low_first: assert property (state == ST_READ
        |=> RSP.valid && RSP.data == $past(OUT_RD_DATA)
        && OUT_RD_ADDR == $past(OUT_RD_ADDR) + ADDR_W'(1))
        else $error("read words out of order");

    c_float_read: cover property (take && !REQ.write && in_float);
    c_pt_block: cover property (state == ST_WRITE && pass_lat
        ##1 PT.pending);
    c_busy: cover property (RSP.exc && RSP.code == EXC_BUSY);
    c_ack: cover property (PT.pending ##1 PT_ACK ##1 !PT.pending);
endmodule

//--- bench/msfp_host.sv
// outbound data image and host model for the pass-through slave
`timescale 1ns/10ps
module msfp_host
    import msfp_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [ADDR_W-1:0] rd_addr,
    output logic      [WORD_W-1:0] rd_data,
    input  wire msfp_pkg::msfp_pt_t pt,
    input  wire logic              stall,
    output logic      [3:0]        idx,
    input  wire logic [WORD_W-1:0] blk_data,
    output logic                   ack
);
    logic [WORD_W-1:0] blk [0:15];
    logic [8:0]        n;
    // outbound words follow their index
    assign rd_data = rd_addr ^ 16'h5A3C;
    initial
    begin
        idx = 4'h0;
        ack = 1'b0;
        n = 9'h000;
    end
    // copy the pending block out, then confirm it
    always @(posedge clk)
    begin
        ack <= 1'b0;
        if (pt.pending && !stall && !ack)
        begin
            if (n > 9'h000)
                blk[n - 9'h001] <= blk_data;
            if (n == pt.word_count)
            begin
                ack <= 1'b1;
                n <= 9'h000;
                idx <= 4'h0;
            end
            else
            begin
                idx <= idx + 4'h1;
                n <= n + 9'h001;
            end
        end
    end
endmodule

//--- bench/msfp_slave_tb_top.sv
// self-checking bench for the float and pass-through slave
`timescale 1ns/10ps
module msfp_slave_tb_top;
    import msfp_pkg::*;
    logic              CORE_CLK;
    logic              RSTN;
    msfp_cfg_t         CFG;
    msfp_req_t         REQ;
    msfp_wdat_t        WDAT;
    logic [ADDR_W-1:0] OUT_RD_ADDR;
    logic [WORD_W-1:0] OUT_RD_DATA;
    msfp_wr_t          IN_WR;
    msfp_rsp_t         RSP;
    msfp_pt_t          PT;
    logic [3:0]        PT_RD_IDX;
    logic [WORD_W-1:0] PT_RD_DATA;
    logic              PT_ACK;
    logic              stall;
    logic [15:0]       seed;
    logic [15:0]       wq [0:31];
    int                n_mismatch;
    int                checks_done;

    msfp_slave #(.PT_DEPTH(16)) i_dut (
        .CORE_CLK(CORE_CLK), .RSTN(RSTN), .CFG(CFG), .REQ(REQ),
        .WDAT(WDAT), .OUT_RD_ADDR(OUT_RD_ADDR), .OUT_RD_DATA(OUT_RD_DATA),
        .IN_WR(IN_WR), .RSP(RSP), .PT(PT), .PT_RD_IDX(PT_RD_IDX),
        .PT_RD_DATA(PT_RD_DATA), .PT_ACK(PT_ACK));
    msfp_host i_host (
        .clk(CORE_CLK), .rd_addr(OUT_RD_ADDR), .rd_data(OUT_RD_DATA),
        .pt(PT), .stall(stall), .idx(PT_RD_IDX), .blk_data(PT_RD_DATA),
        .ack(PT_ACK));

    always #50 CORE_CLK = ~CORE_CLK;

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic isflt(input logic [15:0] a);
        return CFG.float_mode_enable && a >= CFG.float_region_start;
    endfunction
    // word index of the k-th word of a request
    function automatic logic [15:0] widx(input logic [15:0] a, input int k);
        if (isflt(a))
            return CFG.float_region_base + k[15:0]
                + 16'({a - CFG.float_region_start, 1'b0});
        return a + k[15:0];
    endfunction
    function automatic int nwords(input logic [15:0] a, input int c);
        return isflt(a) ? 2 * c : c;
    endfunction

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic give_up(input string m);
        n_mismatch++;
        $display("mismatch at %0t: %s", $time, m);
        close_out();
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string m);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask
    task automatic issue(input logic w, input logic [15:0] a,
                         input logic [7:0] c);
        @(negedge CORE_CLK);
        REQ = '{1'b1, w, a, c};
        @(negedge CORE_CLK);
        REQ.valid = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] c);
        int n;
        int i;
        n = 0;
        issue(1'b0, a, c);
        if (c == 8'h00)
            chk(16'({RSP.exc, RSP.code}), 16'h0103, "zero count");
        for (i = 0; i < 80 && n < nwords(a, c); i++)
        begin
            if (RSP.valid === 1'b1)
            begin
                if (n == 0)
                    chk(16'(i), 16'h0001, "first word delay");
                chk(RSP.data, widx(a, n) ^ 16'h5A3C, "rd data");
                chk(16'(RSP.last), 16'(n == nwords(a, c) - 1), "last");
                n++;
            end
            @(negedge CORE_CLK);
        end
        if (n < nwords(a, c))
            give_up("read words missing");
        chk(16'(RSP.valid), 16'h0000, "extra word");
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] c,
                      input logic [7:0] ec);
        int nw;
        int j;
        logic nrm;
        nw = nwords(a, c);
        nrm = (ec == 8'h00) && !CFG.pass_thru_en;
        issue(1'b1, a, c);
        for (j = 0; j <= nw; j++)
        begin
            if (j == 0 && ec != 8'h00)
                chk(16'({RSP.exc, RSP.code}), 16'({1'b1, ec}), "exc");
            if (j > 0)
            begin
                chk(16'(IN_WR.en), 16'(nrm), "inbound write");
                if (nrm)
                begin
                    chk(IN_WR.addr, widx(a, j - 1), "wr index");
                    chk(IN_WR.data, wq[j - 1], "wr data");
                end
            end
            if (j < nw)
            begin
                seed = lfsr(seed);
                WDAT = '{1'b1, seed};
                if (ec == 8'h00)
                    wq[j] = seed;
            end
            else
            begin
                WDAT.valid = 1'b0;
                chk(16'(RSP.done), 16'(ec == 8'h00), "done");
                if (CFG.pass_thru_en && ec == 8'h00)
                begin
                    chk(16'(PT.pending), 16'h0001, "pending");
                    chk(PT.word_addr, widx(a, 0), "block addr");
                    chk(16'(PT.word_count), 16'(nw), "block size");
                end
            end
            @(negedge CORE_CLK);
        end
    endtask
    task automatic drain();
        int i;
        for (i = 0; i < 100 && PT.pending !== 1'b0; i++)
            @(negedge CORE_CLK);
        if (PT.pending !== 1'b0)
            give_up("block never confirmed");
    endtask

    initial
    begin
        CORE_CLK = 1'b0;
        RSTN = 1'b0;
        CFG = '{1'b0, 16'h1B58, 16'h0064, 1'b0};
        REQ = '0;
        WDAT = '0;
        stall = 1'b0;
        seed = 16'hAE27;
        n_mismatch = 0;
        checks_done = 0;
        repeat (2) @(posedge CORE_CLK);
        @(negedge CORE_CLK);
        chk(16'({RSP.valid, RSP.done, PT.pending}), 16'h0000, "reset");
        RSTN = 1'b1;
        for (int t = 0; t < 4; t++)
        begin
            seed = lfsr(seed);
            rd(seed, 8'(seed[1:0]) + 8'h01);
        end
        rd(16'h1B58, 8'h03);
        $display("test done: standard reads");
        CFG.float_mode_enable = 1'b1;
        rd(16'h1B58, 8'h01);
        rd(16'h1B5D, 8'h02);
        rd(16'h1B59, 8'h01);
        rd(16'h1B57, 8'h01);
        rd(16'h0010, 8'h00);
        $display("test done: float reads");
        wr(16'h0020, 8'h03, 8'h00);
        wr(16'h1B59, 8'h02, 8'h00);
        $display("test done: normal writes");
        CFG.pass_thru_en = 1'b1;
        stall = 1'b1;
        wr(16'h1B5A, 8'h03, 8'h00);
        wr(16'h0040, 8'h01, EXC_BUSY);
        chk(PT.word_addr, 16'h0068, "block kept");
        rd(16'h0040, 8'h02);
        stall = 1'b0;
        drain();
        for (int k = 0; k < 6; k++)
            chk(i_host.blk[k], wq[k], "block word");
        wr(16'h1B58, 8'h09, EXC_VALUE);
        wr(16'h0050, 8'h02, 8'h00);
        drain();
        $display("test done: pass-through");
        close_out();
    end
endmodule
